// ### rtl/fsg_guard.sv
// Flash section access guard: area decode, lock checks, stall and busy flag.
// Notes on behaviour
// - Flash splits into application and boot areas by size fuses; each has lock set.
// - Store instruction from application area never starts programming.
// - Store from boot area may program anywhere, boot area too, subject to locks.
// - Programming a concurrent-read page keeps core running; stalling area stays readable.
// - Programming a stalling-area page halts the core throughout; no reads.
// - Busy flag reads one while concurrent area is blocked by programming.
// - Boot area always lies wholly inside the stalling area.
// - Two independent lock sets: application and boot.
// - Lock bits only get programmed by software or programming mode; chip erase clears.
// - General write lock does not restrict store-instruction programming.
// - General read/write lock does not restrict loads or stores.
// - Both application lock bits unprogrammed: no restriction on application area.
// - Application write guard programmed: stores into application area blocked.
// - Application read guard programmed: boot-area loads of application area refused.
// - Application read guard with boot vectors: interrupts off while in application.
// - Boot write guard programmed: stores into boot area blocked.
// - Boot read guard programmed: application loads of boot area refused.
// - Boot read guard with application vectors: interrupts off while in boot area.
`default_nettype none
module fsg_guard (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Configuration from fuses and vector placement, static after reset.
    input wire logic [1:0] boot_area_size_fuses_i,
    input wire logic vectors_in_boot_i,
    input wire logic [2:0] general_lock_mode_i,
    // Lock set loading from the programming modes and chip erase.
    input wire logic prog_mode_lock_we_i,
    input wire logic [3:0] prog_mode_lock_data_i,
    input wire logic chip_erase_i,
    // Core accesses.
    input wire fsg_pkg::fsg_store_t store_i,
    input wire fsg_pkg::fsg_load_t load_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic [12:0] exec_pc_i,
    input wire logic busy_clear_i,
    // Flash array controls.
    output logic prog_start_o,
    output logic prog_erase_o,
    output logic [12:0] prog_addr_o,
    // Core controls and status.
    output logic core_halt_o,
    output logic concurrent_area_busy_flag_o,
    output logic load_done_o,
    output logic [7:0] load_data_o,
    output logic irq_block_o,
    output logic fetch_block_o,
    output logic store_refused_o,
    output logic [1:0] application_lock_set_o,
    output logic [1:0] boot_lock_set_o
);
    fsg_pkg::fsg_state_s_t s_q, s_d;

    // Start of the boot area for the current fuse setting.
    function automatic logic [12:0] boot_base(input logic [1:0] sz);
        unique case (sz)
            2'h0: boot_base = fsg_pkg::BOOT_BASE_0;
            2'h1: boot_base = fsg_pkg::BOOT_BASE_1;
            2'h2: boot_base = fsg_pkg::BOOT_BASE_2;
            2'h3: boot_base = fsg_pkg::BOOT_BASE_3;
        endcase
    endfunction

    // Address lies in the boot area; every base is at or above the stalling base.
    function automatic logic in_boot(input logic [12:0] a, input logic [1:0] sz);
        in_boot = (a >= boot_base(sz));
    endfunction

    logic st_from_boot, st_to_boot, st_locked, st_ok, st_prog;
    logic ld_from_boot, ld_to_boot, ld_refused, pc_in_boot;

    // Access decisions; the general lock mode is intentionally not consulted.
    always_comb begin
        st_from_boot = in_boot(store_i.pc, boot_area_size_fuses_i);
        st_to_boot = in_boot(store_i.addr, boot_area_size_fuses_i);
        // Locked means the target area's write guard is programmed.
        st_locked = st_to_boot ? !s_q.boot_lock[fsg_pkg::WRITE_GUARD_POS]
                               : !s_q.app_lock[fsg_pkg::WRITE_GUARD_POS];
        st_prog = (store_i.op == fsg_pkg::OP_ERASE) || (store_i.op == fsg_pkg::OP_WRITE);
        // Stores only act from the boot area; leave general lock out.
        st_ok = store_i.valid && st_from_boot && (s_q.state == fsg_pkg::ST_IDLE);
        ld_from_boot = in_boot(load_i.pc, boot_area_size_fuses_i);
        ld_to_boot = in_boot(load_i.addr, boot_area_size_fuses_i);
        ld_refused = (ld_from_boot && !ld_to_boot && !s_q.app_lock[fsg_pkg::READ_GUARD_POS])
                  || (!ld_from_boot && ld_to_boot && !s_q.boot_lock[fsg_pkg::READ_GUARD_POS]);
        pc_in_boot = in_boot(exec_pc_i, boot_area_size_fuses_i);
    end

    // Next-state logic for the whole guard.
    always_comb begin
        s_d = s_q;
        s_d.prog_start = 1'b0;
        s_d.load_done = 1'b0;
        s_d.store_refused = 1'b0;
        unique case (s_q.state)
            fsg_pkg::ST_IDLE: begin
                if (st_ok && st_prog && !st_locked) begin
                    s_d.state = fsg_pkg::ST_PROG;
                    s_d.cnt = fsg_pkg::PROG_CNT_INIT;
                    s_d.prog_start = 1'b1;
                    s_d.prog_erase = (store_i.op == fsg_pkg::OP_ERASE);
                    s_d.prog_addr = store_i.addr;
                    s_d.stall_op = (store_i.addr >= fsg_pkg::STALL_BASE);
                    s_d.core_halt = (store_i.addr >= fsg_pkg::STALL_BASE);
                    if (store_i.addr < fsg_pkg::STALL_BASE) begin
                        s_d.busy_flag = 1'b1;
                    end
                end else if (store_i.valid && st_prog && st_from_boot) begin
                    // Stores from the application area stay silent; only boot code sees refusals.
                    s_d.store_refused = 1'b1;
                end
                if (st_ok && store_i.op == fsg_pkg::OP_BUFFER) begin
                    s_d.busy_flag = 1'b0;
                end
            end
            fsg_pkg::ST_PROG: begin
                // A second erase or write while the engine is busy is dropped.
                if (store_i.valid && st_prog && st_from_boot) begin
                    s_d.store_refused = 1'b1;
                end
                if (s_q.cnt == 10'h001) begin
                    s_d.state = fsg_pkg::ST_IDLE;
                end
                // Halt holds for a stalling-area page until the last counted cycle.
                s_d.core_halt = s_q.stall_op && (s_q.cnt != 10'h001);
                s_d.cnt = s_q.cnt - 10'h001;
            end
        endcase
        // Busy clears only by software after completion.
        if (busy_clear_i && s_q.state == fsg_pkg::ST_IDLE && !s_d.prog_start) begin
            s_d.busy_flag = 1'b0;
        end
        // Lock sets only move toward programmed, except for chip erase.
        if (chip_erase_i) begin
            s_d.app_lock = fsg_pkg::LOCK_ERASED;
            s_d.boot_lock = fsg_pkg::LOCK_ERASED;
        end else if (prog_mode_lock_we_i) begin
            s_d.app_lock = s_q.app_lock & prog_mode_lock_data_i[1:0];
            s_d.boot_lock = s_q.boot_lock & prog_mode_lock_data_i[3:2];
        end else if (st_ok && store_i.op == fsg_pkg::OP_LOCKSET) begin
            s_d.app_lock = s_q.app_lock & store_i.lock_data[1:0];
            s_d.boot_lock = s_q.boot_lock & store_i.lock_data[3:2];
        end
        // Loads get no load_done while the core is halted.
        s_d.load_done = load_i.valid && !s_q.core_halt;
        s_d.load_data = ld_refused ? fsg_pkg::REFUSED_DATA : flash_rdata_i;
        // Interrupts masked when vectors sit in the other area and the executing area is read-guarded.
        s_d.irq_block = (!pc_in_boot && vectors_in_boot_i
                         && !s_q.app_lock[fsg_pkg::READ_GUARD_POS])
                     || (pc_in_boot && !vectors_in_boot_i
                         && !s_q.boot_lock[fsg_pkg::READ_GUARD_POS]);
        // Concurrent area blocked for fetch while busy; software must still avoid it.
        s_d.fetch_block = s_d.busy_flag;
    end

    // State register.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '{state: fsg_pkg::ST_IDLE, app_lock: fsg_pkg::LOCK_ERASED,
                     boot_lock: fsg_pkg::LOCK_ERASED, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops.
    always_comb begin
        prog_start_o = s_q.prog_start;
        prog_erase_o = s_q.prog_erase;
        prog_addr_o = s_q.prog_addr;
        core_halt_o = s_q.core_halt;
        concurrent_area_busy_flag_o = s_q.busy_flag;
        load_done_o = s_q.load_done;
        load_data_o = s_q.load_data;
        irq_block_o = s_q.irq_block;
        fetch_block_o = s_q.fetch_block;
        store_refused_o = s_q.store_refused;
        application_lock_set_o = s_q.app_lock;
        boot_lock_set_o = s_q.boot_lock;
    end
endmodule
`default_nettype wire

// ### rtl/fsg_pkg.sv
// Package for the flash section access guard: layout, lock encodings and timing.
`default_nettype none
package fsg_pkg;
    // Word address width of the program flash.
    localparam int unsigned ADDR_W = 13;
    // First word of the stalling area; the concurrent-read area lies below it.
    localparam logic [12:0] STALL_BASE = 13'h1c00;
    // Boot area start for each setting of the boot size fuses (00 largest).
    localparam logic [12:0] BOOT_BASE_0 = 13'h1c00;
    localparam logic [12:0] BOOT_BASE_1 = 13'h1e00;
    localparam logic [12:0] BOOT_BASE_2 = 13'h1f00;
    localparam logic [12:0] BOOT_BASE_3 = 13'h1f80;
    // Lock bit sets after chip erase: all unprogrammed.
    localparam logic [1:0] LOCK_ERASED = 2'h3;
    // Bit positions inside a lock set (0 means programmed).
    localparam int unsigned WRITE_GUARD_POS = 0;
    localparam int unsigned READ_GUARD_POS = 1;
    // Erase or write duration in cycles at 100 MHz.
    localparam int unsigned PROG_TIME_NS = 4000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] PROG_CNT_INIT = 10'(PROG_CYCLES);
    // Value returned by a refused read.
    localparam logic [7:0] REFUSED_DATA = 8'hff;

    // Operation kind issued with a store access.
    typedef enum logic [1:0] {OP_BUFFER, OP_ERASE, OP_WRITE, OP_LOCKSET} fsg_op_t;

    // Store request from the core.
    typedef struct packed {
        logic valid;
        fsg_op_t op;
        logic [12:0] addr;
        logic [12:0] pc;
        logic [3:0] lock_data;
    } fsg_store_t;

    // Load request from the core.
    typedef struct packed {
        logic valid;
        logic [12:0] addr;
        logic [12:0] pc;
    } fsg_load_t;

    // Programming engine state.
    typedef enum logic [0:0] {ST_IDLE, ST_PROG} fsg_state_t;

    // All state of the guard.
    typedef struct packed {
        fsg_state_t state;
        logic [9:0] cnt;
        logic stall_op;
        logic [1:0] app_lock;
        logic [1:0] boot_lock;
        logic busy_flag;
        logic core_halt;
        logic prog_start;
        logic prog_erase;
        logic [12:0] prog_addr;
        logic [7:0] load_data;
        logic load_done;
        logic irq_block;
        logic fetch_block;
        logic store_refused;
    } fsg_state_s_t;
endpackage
`default_nettype wire

// ### tb/fsg_core_model.sv
// Core model issuing store and load accesses to the guard.
`default_nettype none
module fsg_core_model (
    // Clock.
    input wire logic clk_i,
    // Core accesses.
    output var fsg_pkg::fsg_store_t store_o,
    output var fsg_pkg::fsg_load_t load_o,
    output logic [7:0] rdata_o
);
    // Idle core at time zero.
    initial begin
        store_o = '0;
        load_o = '0;
        rdata_o = 8'h5a;
    end
    // One-cycle store, issued whenever called; the engine state is not checked.
    task automatic put(input fsg_pkg::fsg_op_t op, input logic [12:0] a, p, input logic [3:0] d);
        @(posedge clk_i);
        store_o <= '{1'b1, op, a, p, d};
        @(posedge clk_i);
        store_o.valid <= 1'b0;
    endtask
    // One-cycle load; array data is inverted after it so stale data never matches.
    task automatic get(input logic [12:0] a, p, input logic [7:0] d);
        @(posedge clk_i);
        load_o <= '{1'b1, a, p};
        rdata_o <= d;
        @(posedge clk_i);
        load_o.valid <= 1'b0;
        rdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ### tb/fsg_guard_properties.sv
// Assertion checker for the flash section access guard ports.
`default_nettype none
module fsg_guard_properties (
    // Clock, reset and configuration.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] boot_area_size_fuses_i,
    input wire logic chip_erase_i,
    // Core accesses.
    input wire fsg_pkg::fsg_store_t store_i,
    input wire fsg_pkg::fsg_load_t load_i,
    // Guard outputs.
    input wire logic prog_start_o,
    input wire logic [12:0] prog_addr_o,
    input wire logic core_halt_o,
    input wire logic concurrent_area_busy_flag_o,
    input wire logic load_done_o,
    input wire logic [7:0] load_data_o,
    input wire logic store_refused_o,
    input wire logic [1:0] application_lock_set_o,
    input wire logic [1:0] boot_lock_set_o
);
    logic [12:0] bb;
    // Boot area start follows the size fuses; everything below is application.
    always_comb begin
        case (boot_area_size_fuses_i)
            2'h0: bb = fsg_pkg::BOOT_BASE_0;
            2'h1: bb = fsg_pkg::BOOT_BASE_1;
            2'h2: bb = fsg_pkg::BOOT_BASE_2;
            default: bb = fsg_pkg::BOOT_BASE_3;
        endcase
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_start_pulse: assert property (prog_start_o |=> !prog_start_o) else $error("start too long");
    a_app_store_off: assert property (store_i.valid && store_i.pc < bb |=>
        !prog_start_o && !store_refused_o) else $error("store from application acted");
    a_stall_halt: assert property (prog_start_o && prog_addr_o >= fsg_pkg::STALL_BASE |->
        core_halt_o ##1 core_halt_o [*8]) else $error("stalling op without halt");
    a_rww_running: assert property (prog_start_o && prog_addr_o < fsg_pkg::STALL_BASE |->
        !core_halt_o && concurrent_area_busy_flag_o) else $error("concurrent op wrong");
    a_app_read_guard: assert property (load_i.valid && !core_halt_o && load_i.pc >= bb &&
        load_i.addr < bb && !application_lock_set_o[1] |=> load_done_o &&
        load_data_o == fsg_pkg::REFUSED_DATA) else $error("application read not refused");
    a_boot_read_guard: assert property (load_i.valid && !core_halt_o && load_i.pc < bb &&
        load_i.addr >= bb && !boot_lock_set_o[1] |=> load_done_o &&
        load_data_o == fsg_pkg::REFUSED_DATA) else $error("boot read not refused");
    a_lock_erase: assert property (chip_erase_i |=> application_lock_set_o == 2'h3 &&
        boot_lock_set_o == 2'h3) else $error("erase left locks");
    a_lock_no_rise: assert property (!chip_erase_i |=>
        (application_lock_set_o & ~$past(application_lock_set_o)) == 2'h0 &&
        (boot_lock_set_o & ~$past(boot_lock_set_o)) == 2'h0) else $error("lock bit cleared");
    a_halt_no_load: assert property (core_halt_o && load_i.valid |=> !load_done_o)
        else $error("load answered in halt");
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the flash section access guard.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] BB = fsg_pkg::BOOT_BASE_3;
    logic clk_i = 0, resetn_i = 0, lock_we = 0, erase = 0, clr = 0;
    logic [3:0] lock_d = 4'h0;
    logic [1:0] fuse = 2'h3;
    logic vec = 1'b1;
    logic [2:0] gen_lock = 3'h0;
    logic [12:0] pc = 13'h0000, paddr;
    logic [1:0] app_exp = 2'h3, boot_exp = 2'h3, app_l, boot_l;
    logic [7:0] rd, ldata;
    logic start, erz, halt, busy, ldone, irqb, fblk, refd;
    integer seed = 32'hb904, fails = 0, checked = 0, n;
    fsg_pkg::fsg_store_t st;
    fsg_pkg::fsg_load_t ld;
    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;
    fsg_core_model u_core (.clk_i(clk_i), .store_o(st), .load_o(ld), .rdata_o(rd));
    fsg_guard DUT (.clk_i(clk_i), .resetn_i(resetn_i), .boot_area_size_fuses_i(fuse),
        .vectors_in_boot_i(vec), .general_lock_mode_i(gen_lock), .prog_mode_lock_we_i(lock_we),
        .prog_mode_lock_data_i(lock_d), .chip_erase_i(erase), .store_i(st), .load_i(ld),
        .flash_rdata_i(rd), .exec_pc_i(pc), .busy_clear_i(clr), .prog_start_o(start),
        .prog_erase_o(erz), .prog_addr_o(paddr), .core_halt_o(halt),
        .concurrent_area_busy_flag_o(busy), .load_done_o(ldone), .load_data_o(ldata),
        .irq_block_o(irqb), .fetch_block_o(fblk), .store_refused_o(refd),
        .application_lock_set_o(app_l), .boot_lock_set_o(boot_l));
    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cross-area reads are refused when the target's read guard is programmed.
    function automatic logic [7:0] exp_ld(input logic [12:0] p, a, input logic [7:0] d);
        if ((p >= BB && a < BB && !app_exp[1]) || (p < BB && a >= BB && !boot_exp[1]))
            return fsg_pkg::REFUSED_DATA;
        return d;
    endfunction
    // Random loads biased to hit both areas; general lock level is scrambled too.
    task automatic loads(input int cnt);
        logic [31:0] r;
        repeat (cnt) begin
            r = $random(seed);
            gen_lock <= r[2:0];
            u_core.get(r[20] ? {6'h3f, r[27:21]} : {1'b0, r[31:20]},
                r[0] ? {6'h3f, r[7:1]} : {1'b0, r[19:8]}, r[15:8]);
            #1 chk("ld_done", 1, ldone);
            chk("ld_data", exp_ld(ld.pc, ld.addr, r[15:8]), ldata);
        end
        $display("load batch done");
    endtask
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 chk("app_lock", 2'h3, app_l);
        chk("boot_lock", 2'h3, boot_l);
        loads(16);
        u_core.put(fsg_pkg::OP_ERASE, 13'h0100, 13'h0100, 4'h0);
        #1 chk("app_store", 0, start);
        chk("app_no_ref", 0, refd);
        u_core.put(fsg_pkg::OP_ERASE, 13'h0100, BB, 4'h0);
        #1 chk("rww_start", 1, start);
        chk("rww_busy", 1, busy);
        chk("rww_halt", 0, halt);
        chk("rww_erase", 1, erz);
        chk("rww_addr", 13'h0100, paddr);
        chk("rww_fetch", 1, fblk);
        repeat (405) @(posedge clk_i);
        #1 chk("busy_held", 1, busy);
        u_core.put(fsg_pkg::OP_BUFFER, 13'h0100, 13'h0100, 4'h0);
        #1 chk("buf_app", 1, busy);
        u_core.put(fsg_pkg::OP_BUFFER, 13'h0100, BB, 4'h0);
        #1 chk("buf_clr", 0, busy);
        u_core.put(fsg_pkg::OP_ERASE, 13'h0100, BB, 4'h0);
        repeat (405) @(posedge clk_i);
        #1 chk("busy_again", 1, busy);
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        #1 chk("busy_clr", 0, busy);
        chk("fetch_clr", 0, fblk);
        u_core.put(fsg_pkg::OP_WRITE, 13'h1d00, BB, 4'h0);
        #1 chk("stall_halt", 1, halt);
        chk("stall_addr", 13'h1d00, paddr);
        chk("stall_erase", 0, erz);
        u_core.get(13'h1d00, BB, 8'h3c);
        #1 chk("halt_load", 0, ldone);
        n = 0;
        while (halt && n < 500) begin
            @(posedge clk_i);
            #1 n++;
        end
        if (n >= 500) begin
            fails++;
            conclude();
        end
        chk("halt_len", 16'(fsg_pkg::PROG_CYCLES), 16'(n + 2));
        u_core.put(fsg_pkg::OP_LOCKSET, 13'h0000, BB, 4'b1100);
        app_exp = 2'h0;
        #1 chk("app_lockset", 2'h0, app_l);
        u_core.put(fsg_pkg::OP_WRITE, 13'h0200, BB, 4'h0);
        #1 chk("app_wr_ref", 1, refd);
        chk("app_wr_start", 0, start);
        @(posedge clk_i);
        lock_we <= 1'b1;
        lock_d <= 4'b0011;
        @(posedge clk_i);
        lock_we <= 1'b0;
        pc <= 13'h0040;
        boot_exp = 2'h0;
        @(posedge clk_i);
        #1 chk("boot_lockset", 2'h0, boot_l);
        chk("irq_block", 1, irqb);
        u_core.put(fsg_pkg::OP_WRITE, 13'h1f90, BB, 4'h0);
        #1 chk("boot_wr_ref", 1, refd);
        loads(24);
        @(posedge clk_i);
        vec <= 1'b0;
        pc <= 13'h1f90;
        repeat (2) @(posedge clk_i);
        #1 chk("irq_boot", 1, irqb);
        @(posedge clk_i);
        erase <= 1'b1;
        @(posedge clk_i);
        erase <= 1'b0;
        #1 chk("erase_app", 2'h3, app_l);
        chk("erase_boot", 2'h3, boot_l);
        // Second reset with the largest boot area selected.
        @(posedge clk_i);
        resetn_i <= 1'b0;
        fuse <= 2'h0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 chk("rst_busy", 0, busy);
        u_core.put(fsg_pkg::OP_ERASE, 13'h0100, 13'h1c00, 4'h0);
        #1 chk("fuse_boot", 1, start);
        conclude();
    end
endmodule
bind fsg_guard fsg_guard_properties u_props (.clk_i(clk_i), .resetn_i(resetn_i),
    .boot_area_size_fuses_i(boot_area_size_fuses_i), .chip_erase_i(chip_erase_i),
    .store_i(store_i), .load_i(load_i), .prog_start_o(prog_start_o),
    .prog_addr_o(prog_addr_o), .core_halt_o(core_halt_o),
    .concurrent_area_busy_flag_o(concurrent_area_busy_flag_o), .load_done_o(load_done_o),
    .load_data_o(load_data_o), .store_refused_o(store_refused_o),
    .application_lock_set_o(application_lock_set_o), .boot_lock_set_o(boot_lock_set_o));
`default_nettype wire
